// ==== hdl/bcc_pkg.sv ====
// shared constants and types for the bcd calendar clock
package bcc_pkg;

  // one-second tick derived from the 10 MHz bus clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_MS = 1000;
  localparam int SECOND_CYCLES = SECOND_MS * 1000000 / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_HOUR_MODE = 8'h04;
  localparam logic [7:0] ADDR_TIME = 8'h08;
  localparam logic [7:0] ADDR_CAL = 8'h0C;
  localparam logic [7:0] ADDR_TALARM = 8'h10;
  localparam logic [7:0] ADDR_CALARM = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_STAT_CLR = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
  localparam logic [7:0] ADDR_IRQ_DIS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_VALID = 8'h2C;

  // bit positions
  localparam int MODE_TIME_BIT = 0;
  localparam int MODE_CAL_BIT = 1;
  localparam int HMODE_12H_BIT = 0;
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int VER_TIME_BIT = 0;
  localparam int VER_CAL_BIT = 1;
  localparam int VER_TALARM_BIT = 2;
  localparam int VER_CALARM_BIT = 3;
  localparam int MONTH_EN_BIT = 23;

  // values after reset
  localparam logic [31:0] CAL_RESET = 32'h01819819;
  localparam logic [31:0] ZERO_RESET = 32'h00000000;

  // time word layout; enable bits only used by the time alarm
  typedef struct packed {
    logic hour_en;
    logic pm;
    logic [5:0] hour;
    logic min_en;
    logic [6:0] min;
    logic sec_en;
    logic [6:0] sec;
  } bcc_time_t;

  // calendar word layout; date_en only used by the calendar alarm
  typedef struct packed {
    logic date_en;
    logic rsv1;
    logic [5:0] date;
    logic [2:0] day;
    logic [4:0] month;
    logic [7:0] year;
    logic rsv0;
    logic [6:0] cent;
  } bcc_cal_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bcc_bus_t;

  // update handshake states, gray coded around the loop
  typedef enum logic [1:0] {
    UPD_RUN = 2'h0,
    UPD_STOP = 2'h1,
    UPD_HELD = 2'h3,
    UPD_RESUME = 2'h2
  } bcc_upd_t;

endpackage

// ==== hdl/bcc_clock.sv ====
// bcd time-of-day clock and calendar with alarm and entry checking
// Overview of operation
// - all values kept in bcd; 24-hour and 12-hour with meridiem bit
// - calendar spans 1900..2099 with century 19 or 20 beside year
// - every year divisible by four is leap, 2000 included
// - seconds advance each second, higher counters on lower rollover
// - five alarm fields, each enabled, alarm when all enabled match
// - alarm match sets status flag; interrupt only when enabled
// - seconds-only alarm fires once per minute
// - rejected time or calendar write leaves counter, sets validity flag
// - validity flag cleared only by a later good write
// - alarm writes checked and flagged the same way
// - century must be 19 or 20, year digits valid bcd
// - date 01..31, month 01..12 fitting date and year, day 1..7
// - hour bcd; 24h 00..23 with meridiem clear, 12h 01..12
// - minutes and seconds valid bcd 00..59
// - 12h writes stored and read back as 24h; bit 22 picks range
// - acknowledge flag set once stopped; software clears it
// - time keeps running during a calendar-only update
// - units digit in low four bits, tens above
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module bcc_clock import bcc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = SECOND_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire bcc_bus_t bus,
  output logic [31:0] read_data,
  output logic irq
);

  // bcd helpers; units in the low nibble, tens above
  function automatic logic [7:0] b2i(input logic [7:0] b);
    return b[7:4] * 8'd10 + {4'h0, b[3:0]};
  endfunction

  function automatic logic [7:0] i2b(input logic [7:0] i);
    return {4'(i / 8'd10), 4'(i % 8'd10)};
  endfunction

  function automatic logic bcd_ok(input logic [7:0] b);
    return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] b);
    if (b[3:0] == 4'h9) begin
      return {b[7:4] + 4'h1, 4'h0};
    end
    return b + 8'h01;
  endfunction

  // last date of a month; year divisible by four is leap
  function automatic logic [7:0] last_date(input logic [4:0] m,
                                           input logic [7:0] y);
    logic [7:0] yi;
    yi = b2i(y);
    case (m)
      5'h02: last_date = (yi[1:0] == 2'h0) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  // 12h entry to stored 24h value
  function automatic logic [5:0] to24(input logic [5:0] h,
                                      input logic pm);
    logic [7:0] i;
    i = b2i({2'h0, h});
    if (i == 8'd12) begin
      i = 8'd0;
    end
    if (pm) begin
      i = i + 8'd12;
    end
    return 6'(i2b(i));
  endfunction

  // hour entry check for the current hour mode
  function automatic logic hour_ok(input logic [5:0] h, input logic pm,
                                   input logic m12);
    logic [7:0] hb;
    hb = {2'h0, h};
    if (!bcd_ok(hb)) begin
      return 1'b0;
    end
    if (m12) begin
      return (hb >= 8'h01) && (hb <= 8'h12);
    end
    return (hb <= 8'h23) && !pm;
  endfunction

  function automatic logic ms_ok(input logic [6:0] v);
    return bcd_ok({1'h0, v}) && (v <= 7'h59);
  endfunction

  logic upd_time_reg, upd_cal_reg, mode12_reg;
  logic [6:0] sec_reg, min_reg, cent_reg;
  logic [5:0] hour_reg, date_reg;
  logic [2:0] day_reg;
  logic [4:0] month_reg;
  logic [7:0] year_reg;
  bcc_time_t talarm_reg;
  logic [4:0] amonth_reg;
  logic [5:0] adate_reg;
  logic amonth_en_reg, adate_en_reg;
  logic ack_reg, alarm_reg, match_reg;
  logic [1:0] imr_reg;
  logic [3:0] ver_reg;
  bcc_upd_t upd_reg;
  logic [23:0] tick_cnt_reg;
  logic tick_reg;
  logic [31:0] read_data_reg;
  logic irq_reg;

  bcc_time_t tw;
  bcc_cal_t cw;
  logic wr_time, wr_cal, wr_talarm, wr_calarm;
  logic time_ok, cal_ok, talarm_ok, calarm_ok;
  logic run_time, day_carry, match, alarm_event;

  // write decode; time and calendar loads need the matching stop bit
  assign tw = bus.wdata[23:0];
  assign cw = bus.wdata;
  assign wr_time = bus.wr && (bus.addr == ADDR_TIME) && upd_time_reg;
  assign wr_cal = bus.wr && (bus.addr == ADDR_CAL) && upd_cal_reg;
  assign wr_talarm = bus.wr && (bus.addr == ADDR_TALARM);
  assign wr_calarm = bus.wr && (bus.addr == ADDR_CALARM);

  // entry checks
  assign time_ok = hour_ok(tw.hour, tw.pm, mode12_reg) && ms_ok(tw.min)
                   && ms_ok(tw.sec);
  assign cal_ok = ((cw.cent == 7'h19) || (cw.cent == 7'h20))
    && bcd_ok(cw.year)
    && bcd_ok({2'h0, cw.date}) && (cw.date >= 6'h01)
    && bcd_ok({3'h0, cw.month}) && (cw.month >= 5'h01)
    && (cw.month <= 5'h12)
    && ({2'h0, cw.date} <= last_date(cw.month, cw.year))
    && (cw.day >= 3'd1) && (cw.day <= 3'd7);
  assign talarm_ok = hour_ok(tw.hour, tw.pm, mode12_reg)
    && ms_ok(tw.min) && ms_ok(tw.sec);
  assign calarm_ok = bcd_ok({2'h0, cw.date}) && (cw.date >= 6'h01)
    && bcd_ok({3'h0, cw.month}) && (cw.month >= 5'h01)
    && (cw.month <= 5'h12)
    && ({2'h0, cw.date} <= last_date(cw.month, year_reg));

  // one-second tick from the bus clock, so no crossing is needed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      tick_reg <= 1'b0;
    end
  end

  assign run_time = tick_reg && !upd_time_reg;
  assign day_carry = run_time && (sec_reg == 7'h59)
                     && (min_reg == 7'h59) && (hour_reg == 6'h23);

  // mode and hour-mode registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      upd_time_reg <= 1'b0;
      upd_cal_reg <= 1'b0;
      mode12_reg <= 1'b0;
    end else if (bus.wr && bus.addr == ADDR_MODE) begin
      upd_time_reg <= bus.wdata[MODE_TIME_BIT];
      upd_cal_reg <= bus.wdata[MODE_CAL_BIT];
    end else if (bus.wr && bus.addr == ADDR_HOUR_MODE) begin
      mode12_reg <= bus.wdata[HMODE_12H_BIT];
    end
  end

  // time counters; kept in 24h form whatever the hour mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sec_reg <= ZERO_RESET[6:0];
      min_reg <= ZERO_RESET[6:0];
      hour_reg <= ZERO_RESET[5:0];
    end else if (wr_time) begin
      if (time_ok) begin
        sec_reg <= tw.sec;
        min_reg <= tw.min;
        hour_reg <= mode12_reg ? to24(tw.hour, tw.pm) : tw.hour;
      end
    end else if (run_time) begin
      if (sec_reg == 7'h59) begin
        sec_reg <= 7'h00;
        if (min_reg == 7'h59) begin
          min_reg <= 7'h00;
          hour_reg <= (hour_reg == 6'h23) ? 6'h00
                      : 6'(bcd_inc({2'h0, hour_reg}));
        end else begin
          min_reg <= 7'(bcd_inc({1'h0, min_reg}));
        end
      end else begin
        sec_reg <= 7'(bcd_inc({1'h0, sec_reg}));
      end
    end
  end

  // calendar counters; a midnight during a calendar update is lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      date_reg <= CAL_RESET[29:24];
      day_reg <= CAL_RESET[23:21];
      month_reg <= CAL_RESET[20:16];
      year_reg <= CAL_RESET[15:8];
      cent_reg <= CAL_RESET[6:0];
    end else if (wr_cal) begin
      if (cal_ok) begin
        date_reg <= cw.date;
        day_reg <= cw.day;
        month_reg <= cw.month;
        year_reg <= cw.year;
        cent_reg <= cw.cent;
      end
    end else if (day_carry && !upd_cal_reg) begin
      day_reg <= (day_reg == 3'd7) ? 3'd1 : day_reg + 3'd1;
      if ({2'h0, date_reg} == last_date(month_reg, year_reg)) begin
        date_reg <= 6'h01;
        if (month_reg == 5'h12) begin
          month_reg <= 5'h01;
          if (year_reg == 8'h99) begin
            year_reg <= 8'h00;
            cent_reg <= (cent_reg == 7'h19) ? 7'h20 : 7'h19;
          end else begin
            year_reg <= bcd_inc(year_reg);
          end
        end else begin
          month_reg <= 5'(bcd_inc({3'h0, month_reg}));
        end
      end else begin
        date_reg <= 6'(bcd_inc({2'h0, date_reg}));
      end
    end
  end

  // alarm compare fields, hour held in 24h form
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      talarm_reg <= ZERO_RESET[23:0];
      amonth_reg <= ZERO_RESET[4:0];
      adate_reg <= ZERO_RESET[5:0];
      amonth_en_reg <= 1'b0;
      adate_en_reg <= 1'b0;
    end else if (wr_talarm && talarm_ok) begin
      talarm_reg <= tw;
      talarm_reg.pm <= 1'b0;
      talarm_reg.hour <= mode12_reg ? to24(tw.hour, tw.pm) : tw.hour;
    end else if (wr_calarm && calarm_ok) begin
      amonth_reg <= cw.month;
      adate_reg <= cw.date;
      amonth_en_reg <= bus.wdata[MONTH_EN_BIT];
      adate_en_reg <= cw.date_en;
    end
  end

  // alarm match; edge of the match so a seconds-only alarm fires
  // once per minute and not on every cycle of the matching second
  assign match = (talarm_reg.sec_en || talarm_reg.min_en
      || talarm_reg.hour_en || amonth_en_reg || adate_en_reg)
    && (!talarm_reg.sec_en || sec_reg == talarm_reg.sec)
    && (!talarm_reg.min_en || min_reg == talarm_reg.min)
    && (!talarm_reg.hour_en || hour_reg == talarm_reg.hour)
    && (!amonth_en_reg || month_reg == amonth_reg)
    && (!adate_en_reg || date_reg == adate_reg);
  assign alarm_event = match && !match_reg;

  // update handshake: stop, then acknowledge, then wait for release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      upd_reg <= UPD_RUN;
    end else begin
      case (upd_reg)
        UPD_RUN: begin
          if (upd_time_reg || upd_cal_reg) begin
            upd_reg <= UPD_STOP;
          end
        end
        UPD_STOP: upd_reg <= UPD_HELD;
        UPD_HELD: begin
          if (!upd_time_reg && !upd_cal_reg) begin
            upd_reg <= UPD_RESUME;
          end
        end
        UPD_RESUME: upd_reg <= UPD_RUN;
        default: upd_reg <= UPD_RUN;
      endcase
    end
  end

  // sticky status; a set in the cycle of its clear wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      alarm_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      match_reg <= match;
      if (upd_reg == UPD_STOP) begin
        ack_reg <= 1'b1;
      end else if (bus.wr && bus.addr == ADDR_STAT_CLR
                   && bus.wdata[STAT_ACK_BIT]) begin
        ack_reg <= 1'b0;
      end
      if (alarm_event) begin
        alarm_reg <= 1'b1;
      end else if (bus.wr && bus.addr == ADDR_STAT_CLR
                   && bus.wdata[STAT_ALARM_BIT]) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  // entry validity flags; no software clear path
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ver_reg <= ZERO_RESET[3:0];
    end else begin
      if (wr_time) begin
        ver_reg[VER_TIME_BIT] <= !time_ok;
      end
      if (wr_cal) begin
        ver_reg[VER_CAL_BIT] <= !cal_ok;
      end
      if (wr_talarm) begin
        ver_reg[VER_TALARM_BIT] <= !talarm_ok;
      end
      if (wr_calarm) begin
        ver_reg[VER_CALARM_BIT] <= !calarm_ok;
      end
    end
  end

  // interrupt enables and the registered interrupt line
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      imr_reg <= ZERO_RESET[1:0];
      irq_reg <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == ADDR_IRQ_EN) begin
        imr_reg <= imr_reg | bus.wdata[1:0];
      end else if (bus.wr && bus.addr == ADDR_IRQ_DIS) begin
        imr_reg <= imr_reg & ~bus.wdata[1:0];
      end
      irq_reg <= (ack_reg && imr_reg[STAT_ACK_BIT])
                 || (alarm_reg && imr_reg[STAT_ALARM_BIT]);
    end
  end

  // read data for one cycle only; unmapped reads return zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_data_reg <= ZERO_RESET;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_MODE: read_data_reg <= {30'h0, upd_cal_reg, upd_time_reg};
        ADDR_HOUR_MODE: read_data_reg <= {31'h0, mode12_reg};
        ADDR_TIME: read_data_reg <= {8'h00, 1'b0,
          mode12_reg && (hour_reg >= 6'h12), hour_reg, 1'b0, min_reg,
          1'b0, sec_reg};
        ADDR_CAL: read_data_reg <= {2'h0, date_reg, day_reg, month_reg,
                                    year_reg, 1'b0, cent_reg};
        ADDR_TALARM: read_data_reg <= {8'h00, talarm_reg};
        ADDR_CALARM: read_data_reg <= {adate_en_reg, 1'b0, adate_reg,
          amonth_en_reg, 2'h0, amonth_reg, 16'h0000};
        ADDR_STATUS: read_data_reg <= {30'h0, alarm_reg, ack_reg};
        ADDR_IRQ_MASK: read_data_reg <= {30'h0, imr_reg};
        ADDR_VALID: read_data_reg <= {28'h0, ver_reg};
        default: read_data_reg <= ZERO_RESET;
      endcase
    end else begin
      read_data_reg <= ZERO_RESET;
    end
  end

  assign read_data = read_data_reg;
  assign irq = irq_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence stop_req_s;
    upd_reg == UPD_RUN && (upd_time_reg || upd_cal_reg);
  endsequence
  sequence ack_seen_s;
    upd_reg == UPD_STOP ##1 ack_reg;
  endsequence

  ack_after_stop_a: assert property (
    stop_req_s |=> ack_seen_s) else $error("ack not set after stop");
  time_frozen_a: assert property (
    upd_time_reg && !wr_time |=> sec_reg == $past(sec_reg))
    else $error("seconds moved while stopped");
  cal_keeps_time_a: assert property (
    run_time && upd_cal_reg && !wr_time |=> sec_reg != $past(sec_reg))
    else $error("time stalled during calendar update");
  sec_wrap_a: assert property (
    run_time && sec_reg == 7'h59 && !wr_time |=> sec_reg == 7'h00)
    else $error("seconds did not wrap");
  bad_write_kept_a: assert property (
    wr_time && !time_ok |=> ver_reg[0] && sec_reg == $past(sec_reg))
    else $error("bad time write not rejected");
  ver_clear_a: assert property (
    wr_time && time_ok |=> !ver_reg[0]) else $error("flag not cleared");
  leap_feb_a: assert property (
    day_carry && !upd_cal_reg && !wr_cal && month_reg == 5'h02
    && date_reg == 6'h28
    && 2'(year_reg[1:0] + {year_reg[4], 1'b0}) == 2'h0
    |=> month_reg == 5'h02 && date_reg == 6'h29)
    else $error("leap day skipped");
  alarm_flag_a: assert property (
    alarm_event |=> alarm_reg) else $error("alarm flag not set");
  irq_gate_a: assert property (
    imr_reg == 2'h0 |=> !irq_reg) else $error("masked interrupt raised");
  read_pulse_a: assert property (
    !bus.rd |=> read_data_reg == 32'h00000000)
    else $error("read data held too long");

endmodule // bcc_clock

// ==== sim/bcc_clock_tb.sv ====
// self-checking register-level testbench for the bcd calendar clock
`timescale 1ns/10ps
module bcc_clock_tb import bcc_pkg::*;;
  localparam int TICK = 20;
  localparam int LIMIT = 12000;
  localparam bcc_bus_t IDLE = '{8'h00, 32'h0, 1'b0, 1'b0};
  logic clock;
  logic reset_n;
  bcc_bus_t bus;
  logic [31:0] read_data;
  logic irq;
  int error_cnt;
  int check_count;
  int cyc;
  int t_first;
  logic [31:0] d;
  logic [31:0] ts;
  logic [31:0] bad_cal [6];
  logic [31:0] bad_time [5];

  bcc_clock #(.TICK_CYCLES(TICK)) bcc_clock_i (
    .clock(clock),
    .reset_n(reset_n),
    .bus(bus),
    .read_data(read_data),
    .irq(irq)
  );

  // 10 MHz clock
  always #50 clock = ~clock;

  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // cycle count doubles as timebase for the alarm interval
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, inputs changed right after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    bus <= IDLE;
    #1;
  endtask

  // data stands only in the cycle after the strobe, then reads zero
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus <= IDLE;
    #1 v = read_data;
    @(posedge clock);
    #1 check32("read idle", 32'h0, read_data);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check32(what, exp, v);
  endtask

  // bounded poll until any masked bit reads 1
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input int limit);
    logic [31:0] v;
    int i;
    v = 32'h0;
    for (i = 0; i < limit && (v & m) == 32'h0; i++) begin
      rd(a, v);
    end
    check32("polled bit", m, v & m);
  endtask

  task automatic wait_irq(input int limit);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < limit) begin
      @(posedge clock);
      #1;
      i++;
    end
    check32("irq raised", 32'h1, {31'h0, irq});
  endtask

  // stop counting through the mode bits and take the acknowledge
  task automatic stop(input logic [31:0] m);
    wr(ADDR_MODE, m);
    poll(ADDR_STATUS, 32'h1, 4);
    wr(ADDR_STAT_CLR, 32'h1);
    rd_check("ack cleared", ADDR_STATUS, 32'h0);
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    bus = IDLE;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    // leap day of a non-leap year, century, date, month, day, year digit
    bad_cal = '{32'h29220120, 32'h28220021, 32'h32220020,
                32'h28330020, 32'h28020020, 32'h28220A20};
    // hour 24, meridiem in 24h, minute 60, bad second, bad minute digit
    bad_time = '{32'h00240000, 32'h00400000, 32'h00006000,
                 32'h0000005A, 32'h00001A00};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd_check("time reset", ADDR_TIME, ZERO_RESET);
    rd_check("cal reset", ADDR_CAL, CAL_RESET);
    rd_check("status reset", ADDR_STATUS, ZERO_RESET);
    rd_check("valid reset", ADDR_VALID, ZERO_RESET);
    rd_check("unmapped", 8'h30, 32'h0);
    // calendar-only update: time must keep counting
    stop(32'h2);
    rd(ADDR_TIME, ts);
    repeat (2 * TICK + 2) @(posedge clock);
    rd(ADDR_TIME, d);
    check32("time runs", 32'h1, {31'h0, d !== ts});
    foreach (bad_cal[i]) begin
      wr(ADDR_CAL, bad_cal[i]);
      rd_check("cal flag", ADDR_VALID, 32'h2);
      rd_check("cal kept", ADDR_CAL, CAL_RESET);
    end
    wr(ADDR_CAL, 32'h28220020);
    rd_check("cal flag gone", ADDR_VALID, 32'h0);
    rd_check("cal loaded", ADDR_CAL, 32'h28220020);
    wr(ADDR_MODE, 32'h0);
    stop(32'h1);
    rd(ADDR_TIME, ts);
    foreach (bad_time[i]) begin
      wr(ADDR_TIME, bad_time[i]);
      rd_check("time flag", ADDR_VALID, 32'h1);
      rd_check("time kept", ADDR_TIME, ts);
    end
    // 12-hour entry is read back as the 24-hour value
    wr(ADDR_HOUR_MODE, 32'h1);
    wr(ADDR_TIME, 32'h00410000);
    rd_check("time 12h", ADDR_TIME, 32'h00530000);
    rd_check("12h flag gone", ADDR_VALID, 32'h0);
    wr(ADDR_TIME, 32'h00130000);
    rd_check("12h hour 13", ADDR_VALID, 32'h1);
    wr(ADDR_TIME, 32'h00000000);
    rd_check("12h hour 00", ADDR_VALID, 32'h1);
    rd_check("12h kept", ADDR_TIME, 32'h00530000);
    wr(ADDR_HOUR_MODE, 32'h0);
    wr(ADDR_TIME, 32'h00235959);
    rd_check("time flag gone", ADDR_VALID, 32'h0);
    rd_check("time loaded", ADDR_TIME, 32'h00235959);
    // midnight carries into 29 February of 2000
    wr(ADDR_MODE, 32'h0);
    ts = 32'h00235959;
    for (int i = 0; i < 3 * TICK && ts === 32'h00235959; i++) begin
      rd(ADDR_TIME, ts);
    end
    check32("midnight", 32'h0, ts);
    rd_check("leap day", ADDR_CAL, 32'h29420020);
    // take the running time only once two reads agree
    rd(ADDR_TIME, ts);
    rd(ADDR_TIME, d);
    for (int i = 0; i < 1 && d !== ts; i++) begin
      ts = d;
      rd(ADDR_TIME, d);
    end
    check32("reads agree", ts, d);
    // seconds-only alarm, once each minute
    wr(ADDR_TALARM, 32'h00000083);
    wr(ADDR_IRQ_EN, 32'h2);
    rd_check("irq mask", ADDR_IRQ_MASK, 32'h2);
    wait_irq(70 * TICK);
    t_first = cyc;
    rd(ADDR_TIME, d);
    check32("alarm second", 32'h03, d & 32'h7F);
    rd_check("alarm status", ADDR_STATUS, 32'h2);
    wr(ADDR_STAT_CLR, 32'h2);
    repeat (2) @(posedge clock);
    #1 check32("irq low", 32'h0, {31'h0, irq});
    wait_irq(62 * TICK);
    check32("alarm period", 60 * TICK, cyc - t_first);
    // rejected alarm entries set their flags; the time alarm keeps its old compare values
    wr(ADDR_TALARM, 32'h000000E1);
    rd_check("talarm flag", ADDR_VALID, 32'h4);
    rd_check("talarm kept", ADDR_TALARM, 32'h00000083);
    wr(ADDR_CALARM, 32'h00930000);
    rd_check("calarm flag", ADDR_VALID, 32'hC);
    // masked alarm sets status but leaves the interrupt low
    wr(ADDR_IRQ_DIS, 32'h2);
    wr(ADDR_STAT_CLR, 32'h2);
    rd_check("irq masked", ADDR_IRQ_MASK, 32'h0);
    poll(ADDR_STATUS, 32'h2, 25 * TICK);
    check32("irq stays low", 32'h0, {31'h0, irq});
    end_sim();
  end
endmodule // bcc_clock_tb
